//--- bench/bie_exec_core_asserts.sv
// Purpose: port-level checker for the branch, interrupt-control and increment executor
// Assumes: one clock domain, synchronous active-low reset
// Notes: sees only top-level ports; bound after the module
`timescale 1ns/100ps
`default_nettype none
module bie_exec_core_asserts
  import bie_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic global_irq_enable_out,
  input wire logic busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  // ----------------------------------------------------------------
  // instruction shapes seen through busy_out
  // ----------------------------------------------------------------
  sequence s_one_cycle;
    $rose(busy_out) ##1 !busy_out;
  endsequence
  sequence s_branch;
    $rose(busy_out) ##1 busy_out ##1 !busy_out;
  endsequence
  sequence s_soft_int;
    $rose(busy_out) ##1 busy_out[*2];
  endsequence

  // reset clears state regardless of the default disable
  a_reset_clears: assert property (disable iff (1'b0) !rst_b_in |=>
    (pc_out == PC_RST) && !global_irq_enable_out && !busy_out)
    else $error("state not cleared by reset");
  // no instruction may run longer than three cycles
  a_busy_bounded: assert property ($rose(busy_out) |-> ##[1:3] !busy_out)
    else $error("instruction overran three cycles");
  // interrupt enable only moves on the single exec cycle
  a_gie_step: assert property ($changed(global_irq_enable_out) |->
    $past(busy_out) && !busy_out)
    else $error("interrupt enable changed outside a one-cycle op");
  // single-cycle ops advance the program counter by one
  a_short_step: assert property (s_one_cycle |-> pc_out == $past(pc_out) + PC_STEP)
    else $error("one-cycle op did not step pc");
  // discarded slot is a nop: pc holds on the second cycle
  a_branch_nop: assert property (s_branch |-> $stable(pc_out))
    else $error("pc moved during discarded slot");
  // software interrupt ends on the vector
  a_soft_vector: assert property (s_soft_int |-> pc_out == SOFT_INT_VECTOR)
    else $error("software interrupt missed vector");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
endmodule
bind bie_exec_core bie_exec_core_asserts bie_exec_core_asserts_i (.clk_sys_in, .rst_b_in,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .pc_out, .global_irq_enable_out, .busy_out);
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench for the executor through its AXI4-Lite port
// Assumes: 40 MHz clock, synchronous active-low reset held four cycles
// Notes: handshakes are judged at the falling edge, so no race with the design's flops
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bie_pkg::*;
  logic clk_sys_in, rst_b_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, global_irq_enable_out, busy_out;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [PC_W-1:0] pc_out;
  int mismatches, tests_run, cycles;

  bie_exec_core bie_exec_core_i (.clk_sys_in, .rst_b_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pc_out, .global_irq_enable_out, .busy_out);

  // ----------------------------------------------------------------
  // clock, watchdog and report
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // whole run is well under two hundred cycles, so this ceiling only trips on a hang
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // ----------------------------------------------------------------
  // bus master: hold each channel until its ready is seen
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    @(posedge clk_sys_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk_sys_in);
      if (s_axi_awvalid && s_axi_awready === 1'b1) aw_ok = 1'b1;
      if (s_axi_wvalid && s_axi_wready === 1'b1) w_ok = 1'b1;
      @(posedge clk_sys_in);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clk_sys_in); while (s_axi_bvalid !== 1'b1);
    // bready comes one edge late so the response must stand unanswered
    @(posedge clk_sys_in);
    s_axi_bready <= 1'b1;
    @(negedge clk_sys_in);
    check(32'(s_axi_bresp), 32'(er));
    @(posedge clk_sys_in);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_sys_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk_sys_in); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys_in);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys_in); while (s_axi_rvalid !== 1'b1);
    // rready comes one edge late so the read data must stand unanswered
    @(posedge clk_sys_in);
    s_axi_rready <= 1'b1;
    @(negedge clk_sys_in);
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(er));
    @(posedge clk_sys_in);
    s_axi_rready <= 1'b0;
  endtask
  // issue one instruction and wait for it to retire
  task automatic run_op(input logic [2:0] op, input logic [5:0] idx, input logic dst,
    input logic [8:0] imm);
    wr(REG_ISSUE, (32'(op) << ISSUE_OP_LSB) | (32'(idx) << ISSUE_REG_LSB)
      | (32'(dst) << ISSUE_DEST_BIT) | (32'(imm) << ISSUE_IMM_LSB), RESP_OKAY);
    do @(negedge clk_sys_in); while (busy_out !== 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_irq();
    run_op(OP_GLOBAL_INT_ENABLE, 6'h00, 1'b0, 9'h000);
    check(32'(global_irq_enable_out), 32'h1);
    rd(REG_STATUS, 32'h2, RESP_OKAY);
    run_op(OP_GLOBAL_INT_DISABLE, 6'h00, 1'b0, 9'h000);
    check(32'(global_irq_enable_out), 32'h0);
    run_op(OP_SPARE_6, 6'h00, 1'b0, 9'h000);
    check(32'(pc_out), 32'h3); // spare code is a nop that steps pc
  endtask
  task automatic t_imm_branch();
    wr(REG_PC_HIGH_BUFFER, 32'h2, RESP_OKAY);
    run_op(OP_IMMEDIATE_BRANCH, 6'h00, 1'b0, 9'h1a5);
    check(32'(pc_out), 32'h3a5);
    wr(REG_PC_HIGH_BUFFER, 32'h1, RESP_OKAY); // bit 0 must not reach pc
    run_op(OP_IMMEDIATE_BRANCH, 6'h00, 1'b0, 9'h0ff);
    check(32'(pc_out), 32'h0ff);
  endtask
  task automatic t_acc_branch_soft_int();
    wr(REG_ACCUMULATOR, 32'h34, RESP_OKAY);
    wr(REG_TABLE_HIGH_POINTER, 32'h2, RESP_OKAY);
    run_op(OP_ACCUMULATOR_BRANCH, 6'h00, 1'b0, 9'h000);
    check(32'(pc_out), 32'h234);
    run_op(OP_SOFT_INTERRUPT, 6'h00, 1'b0, 9'h000);
    rd(REG_STACK_TOP, 32'h235, RESP_OKAY);
    check(32'(pc_out), 32'(SOFT_INT_VECTOR));
  endtask
  task automatic t_increment_op();
    // top register index and wrap to zero
    wr(REG_RF_INDEX, 32'h3f, RESP_OKAY);
    wr(REG_RF_DATA, 32'hff, RESP_OKAY);
    run_op(OP_INCREMENT, 6'h3f, 1'b1, 9'h000);
    rd(REG_RF_DATA, 32'h00, RESP_OKAY);
    rd(REG_STATUS, 32'h4, RESP_OKAY);
    wr(REG_RF_DATA, 32'h10, RESP_OKAY);
    run_op(OP_INCREMENT, 6'h3f, 1'b0, 9'h000);
    rd(REG_ACCUMULATOR, 32'h11, RESP_OKAY);
    rd(REG_RF_DATA, 32'h10, RESP_OKAY);
    rd(REG_STATUS, 32'h0, RESP_OKAY);
  endtask
  task automatic t_bus_faults();
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(REG_STATUS, 32'h2, RESP_SLVERR);
    rd(REG_STATUS, 32'h0, RESP_OKAY);
  endtask

  initial begin
    rst_b_in = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(negedge clk_sys_in);
    check(32'({busy_out, global_irq_enable_out, pc_out}), 32'h0);
    t_irq();
    t_imm_branch();
    t_acc_branch_soft_int();
    t_increment_op();
    t_bus_faults();
    complete_run();
  end
endmodule
`default_nettype wire

//--- inc/bie_pkg.sv
// Purpose: shared constants and types of the branch, interrupt-control and increment executor
// Assumes: one instruction cycle per clk_sys_in cycle, registers reached over AXI4-Lite
// Notes: byte offsets are 32-bit aligned words; unlisted bits read as zero, except the issue word, which reads back the packed instruction
package bie_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam int PC_W = 10;
  localparam int IMM_W = 9;
  localparam int DATA_W = 8;
  localparam int RF_IDX_W = 6;
  localparam int HI_W = 2;
  localparam int OP_W = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AXI_ADDR_W-1:0] REG_ISSUE = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_PC = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_ACCUMULATOR = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] REG_PC_HIGH_BUFFER = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] REG_TABLE_HIGH_POINTER = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] REG_STACK_TOP = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] REG_RF_INDEX = 8'h1c;
  localparam logic [AXI_ADDR_W-1:0] REG_RF_DATA = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ISSUE_OP_LSB = 0;
  localparam int ISSUE_REG_LSB = 8;
  localparam int ISSUE_DEST_BIT = 16;
  localparam int ISSUE_IMM_LSB = 20;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_GIE_BIT = 1;
  localparam int ST_ZERO_BIT = 2;
  localparam int PCHB_PC9_BIT = 1;

  // ----------------------------------------------------------------
  // reset values and fixed addresses
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [HI_W-1:0] HI_RST = 2'h0;
  localparam logic [PC_W-1:0] SOFT_INT_VECTOR = 10'h001;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;
  localparam logic [DATA_W-1:0] INC_STEP = 8'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // instruction codes and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    OP_GLOBAL_INT_DISABLE = 3'h0,
    OP_GLOBAL_INT_ENABLE = 3'h1,
    OP_IMMEDIATE_BRANCH = 3'h2,
    OP_ACCUMULATOR_BRANCH = 3'h3,
    OP_INCREMENT = 3'h4,
    OP_SOFT_INTERRUPT = 3'h5,
    OP_SPARE_6 = 3'h6,
    OP_SPARE_7 = 3'h7
  } bie_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXEC = 4'h2,
    ST_VECTOR = 4'h4,
    ST_DISCARD = 4'h8
  } bie_state_t;

  typedef struct packed {
    bie_op_t op;
    logic [RF_IDX_W-1:0] reg_idx;
    logic dest;
    logic [IMM_W-1:0] imm;
  } bie_instr_t;

  typedef struct packed {
    logic [AXI_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } bie_bus_wr_t;

endpackage

//--- logic/bie_axil_slave.sv
// Purpose: AXI4-Lite slave front end of the executor
// Assumes: one write and one read outstanding at most
// Notes: address and data accepted in either order; decode errors come from the core
`timescale 1ns/100ps
`default_nettype none
module bie_axil_slave
  import bie_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output var bie_bus_wr_t wr_req_out,
  output logic wr_fire_out,
  input wire logic wr_err_in,
  output logic [AXI_ADDR_W-1:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_err_in
);

  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  bie_bus_wr_t wr_r, wr_nxt;

  // ----------------------------------------------------------------
  // write and read channels
  // ----------------------------------------------------------------
  // the core decodes from the held request, so the write fires one cycle after both parts land
  assign wr_fire_out = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_req_out = wr_r;
  assign rd_addr_out = s_axi_araddr;

  always_comb begin
    wr_nxt = wr_r;
    aw_hold_r_next_block: begin
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt = w_hold_r;
    end
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && awready_r) begin
      wr_nxt.addr = s_axi_awaddr;
      aw_hold_nxt = 1'b1;
    end
    if (s_axi_wvalid && wready_r) begin
      wr_nxt.data = s_axi_wdata;
      wr_nxt.strb = s_axi_wstrb;
      w_hold_nxt = 1'b1;
    end
    if (wr_fire_out) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_err_in ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_data_in;
      rresp_nxt = rd_err_in ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // no new part is taken while a response is still waiting
    awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
    wready_nxt = ~w_hold_nxt & ~bvalid_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wr_r <= '0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      wr_r <= wr_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule
`default_nettype wire

//--- logic/bie_exec_core.sv
// Purpose: executes interrupt enable/disable, both branches, increment and software interrupt
// Assumes: one instruction cycle per clk_sys_in cycle; instructions issued over AXI4-Lite
// Notes: register writes other than reads are ignored while an instruction runs
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - disable clears interrupt enable, one cycle
// - enable sets interrupt enable, one cycle
// - immediate branch loads pc[8:0], two cycles
// - immediate branch takes pc[9] from buffer bit1
// - accumulator branch loads pointer and accumulator
// - increment register to accumulator or back, zero flag
// - software interrupt pushes pc plus one
// - then vector 0x001 loaded, three cycles total
module bie_exec_core
  import bie_pkg::*;
#(
  parameter int STACK_DEPTH = 2,
  parameter int RF_DEPTH = 64
)(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [PC_W-1:0] pc_out,
  output logic global_irq_enable_out,
  output logic busy_out
);

  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (STACK_DEPTH < 1 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_stack
    $error("STACK_DEPTH must be a power of two");
  end
  if (RF_DEPTH != (1 << RF_IDX_W)) begin : g_bad_rf
    $error("RF_DEPTH must match the register index width");
  end

  bie_bus_wr_t wr_req;
  logic wr_fire, wr_err, rd_err;
  logic [AXI_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data, wr_mask, wr_val;

  bie_state_t state_r, state_nxt;
  bie_instr_t instr_r, instr_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [HI_W-1:0] pchb_r, pchb_nxt, table_high_pointer_r, table_high_pointer_nxt;
  logic [RF_IDX_W-1:0] rf_idx_r, rf_idx_nxt;
  logic gie_r, gie_nxt, zero_r, zero_nxt, busy_r, busy_nxt;
  logic [SP_W-1:0] sp_r, sp_nxt, sp_top;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [DATA_W-1:0] rf_r [RF_DEPTH], rf_nxt [RF_DEPTH];
  logic [DATA_W-1:0] inc_res;
  logic idle, bus_wr, push, rf_exec_wr, rf_bus_wr;

  bie_axil_slave bie_axil_slave_i (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wr_req_out(wr_req), .wr_fire_out(wr_fire),
    .wr_err_in(wr_err), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
    .rd_err_in(rd_err)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // byte strobes merge new lanes over the old word, except the issue word, where lanes not strobed read as zero
  assign wr_mask = {{8{wr_req.strb[3]}}, {8{wr_req.strb[2]}}, {8{wr_req.strb[1]}},
                    {8{wr_req.strb[0]}}};
  assign idle = (state_r == ST_IDLE);
  assign bus_wr = wr_fire & idle;
  assign sp_top = sp_r - SP_W'(1);
  assign inc_res = rf_r[instr_r.reg_idx] + INC_STEP;

  always_comb begin
    wr_err = 1'b0;
    unique case (wr_req.addr)
      REG_ISSUE, REG_PC, REG_ACCUMULATOR, REG_PC_HIGH_BUFFER, REG_TABLE_HIGH_POINTER,
      REG_RF_INDEX, REG_RF_DATA: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  // read mux; status and stack top are read-only views of the core
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    unique case (rd_addr)
      REG_ISSUE: rd_data = 32'(instr_r);
      REG_STATUS: begin
        rd_data[ST_BUSY_BIT] = busy_r;
        rd_data[ST_GIE_BIT] = gie_r;
        rd_data[ST_ZERO_BIT] = zero_r;
      end
      REG_PC: rd_data = 32'(pc_r);
      REG_ACCUMULATOR: rd_data = 32'(acc_r);
      REG_PC_HIGH_BUFFER: rd_data = 32'(pchb_r);
      REG_TABLE_HIGH_POINTER: rd_data = 32'(table_high_pointer_r);
      REG_STACK_TOP: rd_data = 32'(stack_r[sp_top]);
      REG_RF_INDEX: rd_data = 32'(rf_idx_r);
      REG_RF_DATA: rd_data = 32'(rf_r[rf_idx_r]);
      default: rd_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // instruction sequencer
  // ----------------------------------------------------------------
  always_comb begin
    wr_val = 32'h0000_0000;
    state_nxt = state_r;
    instr_nxt = instr_r;
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    pchb_nxt = pchb_r;
    table_high_pointer_nxt = table_high_pointer_r;
    rf_idx_nxt = rf_idx_r;
    gie_nxt = gie_r;
    zero_nxt = zero_r;
    sp_nxt = sp_r;
    push = 1'b0;
    rf_exec_wr = 1'b0;
    rf_bus_wr = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (bus_wr) begin
          unique case (wr_req.addr)
            REG_ISSUE: begin
              // an issue word always takes effect as a whole; lanes not strobed read as zero
              wr_val = wr_req.data & wr_mask;
              instr_nxt.op = bie_op_t'(wr_val[ISSUE_OP_LSB +: OP_W]);
              instr_nxt.reg_idx = wr_val[ISSUE_REG_LSB +: RF_IDX_W];
              instr_nxt.dest = wr_val[ISSUE_DEST_BIT];
              instr_nxt.imm = wr_val[ISSUE_IMM_LSB +: IMM_W];
              state_nxt = ST_EXEC;
            end
            REG_PC: begin
              wr_val = (32'(pc_r) & ~wr_mask) | (wr_req.data & wr_mask);
              pc_nxt = wr_val[PC_W-1:0];
            end
            REG_ACCUMULATOR: begin
              wr_val = (32'(acc_r) & ~wr_mask) | (wr_req.data & wr_mask);
              acc_nxt = wr_val[DATA_W-1:0];
            end
            REG_PC_HIGH_BUFFER: begin
              wr_val = (32'(pchb_r) & ~wr_mask) | (wr_req.data & wr_mask);
              pchb_nxt = wr_val[HI_W-1:0];
            end
            REG_TABLE_HIGH_POINTER: begin
              wr_val = (32'(table_high_pointer_r) & ~wr_mask) | (wr_req.data & wr_mask);
              table_high_pointer_nxt = wr_val[HI_W-1:0];
            end
            REG_RF_INDEX: begin
              wr_val = (32'(rf_idx_r) & ~wr_mask) | (wr_req.data & wr_mask);
              rf_idx_nxt = wr_val[RF_IDX_W-1:0];
            end
            REG_RF_DATA: begin
              wr_val = (32'(rf_r[rf_idx_r]) & ~wr_mask) | (wr_req.data & wr_mask);
              rf_bus_wr = 1'b1;
            end
            default: wr_val = 32'h0000_0000;
          endcase
        end
      end
      ST_EXEC: begin
        state_nxt = ST_IDLE;
        pc_nxt = pc_r + PC_STEP;
        unique case (instr_r.op)
          OP_GLOBAL_INT_DISABLE: gie_nxt = 1'b0;
          OP_GLOBAL_INT_ENABLE: gie_nxt = 1'b1;
          OP_IMMEDIATE_BRANCH: begin
            pc_nxt = {pchb_r[PCHB_PC9_BIT], instr_r.imm};
            state_nxt = ST_DISCARD;
          end
          OP_ACCUMULATOR_BRANCH: begin
            pc_nxt = {table_high_pointer_r, acc_r};
            state_nxt = ST_DISCARD;
          end
          OP_INCREMENT: begin
            // destination bit picks accumulator or the source register
            zero_nxt = (inc_res == DATA_RST);
            if (instr_r.dest) begin
              rf_exec_wr = 1'b1;
            end else begin
              acc_nxt = inc_res;
            end
          end
          OP_SOFT_INTERRUPT: begin
            push = 1'b1;
            sp_nxt = sp_r + SP_W'(1);
            pc_nxt = pc_r;
            state_nxt = ST_VECTOR;
          end
          default: pc_nxt = pc_r + PC_STEP; // spare codes run as a plain nop
        endcase
      end
      ST_VECTOR: begin
        pc_nxt = SOFT_INT_VECTOR;
        state_nxt = ST_DISCARD;
      end
      ST_DISCARD: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
  end

  // ----------------------------------------------------------------
  // register file, one entry per loop pass
  // ----------------------------------------------------------------
  for (genvar i = 0; i < RF_DEPTH; i++) begin : g_rf
    always_comb begin
      rf_nxt[i] = rf_r[i];
      if (rf_exec_wr && instr_r.reg_idx == RF_IDX_W'(i)) begin
        rf_nxt[i] = inc_res;
      end else if (rf_bus_wr && rf_idx_r == RF_IDX_W'(i)) begin
        rf_nxt[i] = wr_val[DATA_W-1:0];
      end
    end
    always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
        rf_r[i] <= DATA_RST;
      end else begin
        rf_r[i] <= rf_nxt[i];
      end
    end
  end

  // stack has no overflow check; the pointer wraps and overwrites the oldest entry
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      for (int j = 0; j < STACK_DEPTH; j++) begin
        stack_r[j] <= PC_RST;
      end
    end else if (push) begin
      stack_r[sp_r] <= pc_r + PC_STEP;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_r <= ST_IDLE;
      instr_r <= '0;
      pc_r <= PC_RST;
      acc_r <= DATA_RST;
      pchb_r <= HI_RST;
      table_high_pointer_r <= HI_RST;
      rf_idx_r <= '0;
      gie_r <= 1'b0;
      zero_r <= 1'b0;
      sp_r <= '0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      pchb_r <= pchb_nxt;
      table_high_pointer_r <= table_high_pointer_nxt;
      rf_idx_r <= rf_idx_nxt;
      gie_r <= gie_nxt;
      zero_r <= zero_nxt;
      sp_r <= sp_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign pc_out = pc_r;
  assign global_irq_enable_out = gie_r;
  assign busy_out = busy_r;

endmodule
`default_nettype wire
